// File: dv/ebac_master.sv
// Two-wire bus master model; clock stands high between frames
`timescale 1ns/1ps
module ebac_master (
  output logic scl,
  output logic sda_m,
  input wire logic sda
);
  // Idle bus, data released to the pull-up
  initial
  begin
    scl = 1'b1;
    sda_m = 1'b1;
  end
  // Data set while clock low, sampled before the fall
  task automatic bit_io(input logic b, output logic r);
    sda_m = b;
    #8 scl = 1'b1;
    #16 r = sda;
    scl = 1'b0;
    #8;
  endtask : bit_io
  // Start or repeated start, long high for the synchroniser
  task automatic start();
    sda_m = 1'b1;
    #8 scl = 1'b1;
    #60 sda_m = 1'b0;
    #60 scl = 1'b0;
    #8;
  endtask : start
  task automatic stop();
    sda_m = 1'b0;
    #8 scl = 1'b1;
    #60 sda_m = 1'b1;
    #60;
  endtask : stop
  // Byte out, MSB first; low in the ninth slot is an ack
  task automatic wbyte(input logic [7:0] v, output logic ak);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(v[i], r);
    bit_io(1'b1, r);
    ak = ~r;
  endtask : wbyte
  task automatic rbyte(input logic last, output logic [7:0] v);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(1'b1, v[i]);
    bit_io(last, r);
  endtask : rbyte
endmodule : ebac_master

// File: dv/ebac_top_sva.sv
// Port checker for the EEPROM front end
`timescale 1ns/1ps
module ebac_top_sva #(
  parameter int WR_CYCLES = 200
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic scl,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe_n,
  input wire logic [3:0] bus_address_setting,
  input wire logic software_write_guard,
  input wire logic config_write_unlock_latch,
  input wire logic id_page_locked,
  input wire logic write_busy,
  input wire logic config_loaded
);
  int unsigned rc; // Cycles since reset, saturating
  int unsigned bc; // Length of the current write cycle
  // Helper counters
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rc <= 0;
      bc <= 0;
    end
    else
    begin
      rc <= (rc < 20) ? rc + 1 : rc;
      bc <= write_busy ? bc + 1 : 0;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  chk_drive_low: assert property (sda_out == 1'b0) else $error("data pin driven high");
  chk_ack_on_low: assert property ($changed(sda_oe_n) |-> !scl)
    else $error("data changed while clock high");
  chk_load_wait: assert property (rc < 8 |-> !config_loaded)
    else $error("load finished too early");
  chk_quiet_unloaded: assert property (!config_loaded |-> sda_oe_n)
    else $error("answer before load");
  chk_busy_len: assert property (bc <= WR_CYCLES) else $error("write cycle too long");
  chk_busy_after_stop: assert property ($rose(write_busy) |-> scl)
    else $error("write cycle began mid frame");
  chk_cda_guarded: assert property ($past(software_write_guard) |-> $stable(bus_address_setting))
    else $error("address setting changed under guard");
  chk_lock_sticky: assert property ($past(id_page_locked) |-> id_page_locked)
    else $error("page lock cleared");
  cover property ($rose(write_busy));
  cover property ($rose(id_page_locked));
  cover property ($changed(bus_address_setting));
endmodule : ebac_top_sva
bind ebac_top ebac_top_sva #(.WR_CYCLES(WR_CYCLES)) ebac_top_sva_i (.clk(clk), .rst_n(rst_n),
  .scl(scl), .sda_in(sda_in), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
  .bus_address_setting(bus_address_setting), .software_write_guard(software_write_guard),
  .config_write_unlock_latch(config_write_unlock_latch), .id_page_locked(id_page_locked),
  .write_busy(write_busy), .config_loaded(config_loaded));

// File: dv/eeprom_bus_address_config_tb_top.sv
// Testbench for the EEPROM address and configuration front end
`timescale 1ns/1ps
`define CK(a, e) begin n_checks++; if ((a) !== (e)) begin n_fail++; $display("Error %0t got %h exp %h", $time, a, e); end end
module eeprom_bus_address_config_tb_top;
  localparam logic [127:0] UIDV = 128'h1F2E_3D4C_5B6A_7988_97A6_B5C4_D3E2_F1A0; // Arbitrary
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic scl, sda_m, sda_out, sda_oe_n, guard, latch, lock, write_busy, loaded, a;
  logic [3:0] cda;
  logic [7:0] d, q0, q1;
  logic [15:0] wa;
  int n_fail = 0;
  int n_checks = 0;
  wire sda = sda_m & (sda_oe_n | sda_out); // Open drain with pull-up
  always #5 clk = ~clk;
  ebac_master ebac_master_i (.scl(scl), .sda_m(sda_m), .sda(sda));
  ebac_top #(.WR_CYCLES(200), .UID_VALUE(UIDV)) ebac_top_i (.clk(clk), .rst_n(rst_n),
    .scl(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe_n(sda_oe_n), .bus_address_setting(cda),
    .software_write_guard(guard), .config_write_unlock_latch(latch), .id_page_locked(lock),
    .write_busy(write_busy), .config_loaded(loaded));
  // Write command; waits out the write cycle
  task automatic wr(input logic [7:0] dv, input logic [15:0] w, input logic [7:0] dt, input bit nd);
    ebac_master_i.start();
    ebac_master_i.wbyte(dv, a);
    ebac_master_i.wbyte(w[15:8], a);
    ebac_master_i.wbyte(w[7:0], a);
    if (nd) ebac_master_i.wbyte(dt, a);
    ebac_master_i.stop();
    repeat (10) @(posedge clk);
    for (int k = 0; k < 400 && write_busy !== 1'b0; k++) @(posedge clk);
  endtask : wr
  // Random read of two bytes: address set by a write that ends in a stop, then a new start
  task automatic rd(input logic [7:0] dv, input logic [15:0] w);
    wr(dv, w, 8'h00, 1'b0);
    ebac_master_i.start();
    ebac_master_i.wbyte(dv | 8'h01, a);
    ebac_master_i.rbyte(1'b0, q0);
    ebac_master_i.rbyte(1'b1, q1);
    ebac_master_i.stop();
  endtask : rd
  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : end_sim
  // Watchdog
  initial
  begin
    #600000;
    n_fail++;
    end_sim();
  end
  initial
  begin
    void'($urandom(32'h48C7AD5F));
    repeat (20) @(posedge clk);
    `CK({cda, guard, latch}, 6'h00)
    #1 rst_n = 1'b1;
    #1000;
    // Prefix and select decode; factory setting needs select 000
    for (int i = 0; i < 16; i++)
    begin
      d = (i == 0) ? 8'hB0 : (i == 1) ? 8'h20 : {3'h5, 5'($urandom)} & 8'hFE;
      ebac_master_i.start();
      ebac_master_i.wbyte(d, a);
      ebac_master_i.stop();
      `CK(a, d[7:5] == 3'h5 && d[3:1] == 3'h0)
    end
    $display("decode test done");
    wa = 16'($urandom) & 16'h1FFF;
    d = 8'($urandom);
    wr(8'hA0, wa, d, 1'b1);
    rd(8'hA0, wa);
    `CK(q0, d)
    rd(8'hB0, 16'h020F);
    `CK({q0, q1}, {UIDV[7:0], UIDV[127:120]})
    wr(8'hB0, 16'h0200, d, 1'b1);
    `CK(a, 1'b0)
    wr(8'hB0, 16'h0003, 8'h5A, 1'b1);
    rd(8'hB0, 16'h0003);
    `CK(q0, 8'h5A)
    wr(8'hB0, 16'h0400, 8'h02, 1'b1);
    rd(8'hB0, 16'h0400);
    `CK({lock, q1}, 9'h102)
    wr(8'hB0, 16'h0003, 8'hA5, 1'b1);
    `CK(a, 1'b0)
    $display("area test done");
    rd(8'hB0, 16'h06CA);
    `CK(q0, 8'h0D)
    wr(8'hB0, 16'h06CA, 8'h92, 1'b1);
    `CK(a, 1'b0)
    wr(8'hB0, 16'h3F35, 8'h00, 1'b0);
    `CK(latch, 1'b1)
    wr(8'hB0, 16'h06CA, 8'h92, 1'b1);
    `CK({cda, guard, latch}, 6'h26)
    wr(8'hA4, wa, d, 1'b1);
    `CK(a, 1'b0)
    wr(8'hB0, 16'h3F35, 8'h00, 1'b0);
    wr(8'hB0, 16'h06CA, 8'h00, 1'b1);
    `CK({cda, guard}, 5'h12)
    $display("config test done");
    end_sim();
  end
endmodule : eeprom_bus_address_config_tb_top

// File: logic/ebac_mem.sv
// Byte memory with one write port and a registered read port
`timescale 1ns/1ps
module ebac_mem #(
  parameter int AW = 5,
  parameter int DW = 8
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic [DW-1:0] wdata,
  input wire logic [AW-1:0] raddr,
  output logic [DW-1:0] rdata
);

  // Storage, not reset: contents model nonvolatile cells
  logic [DW-1:0] mem_reg [0:(1<<AW)-1];

  // Write port
  always_ff @(posedge clk)
  begin
    if (we)
    begin
      mem_reg[waddr] <= wdata;
    end
  end

  // Registered read; a same-edge write to raddr returns the old byte
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rdata <= '0;
    end
    else
    begin
      rdata <= mem_reg[raddr];
    end
  end

endmodule : ebac_mem

// File: logic/ebac_pkg.sv
// Shared constants and types for the two-wire EEPROM address and configuration front end
package ebac_pkg;

  // Data and address widths
  localparam int BYTE_W = 8;
  localparam int MAIN_AW = 13;
  localparam int ID_AW = 5;
  localparam int UID_AW = 4;
  localparam int WA_W = 14;

  // Device-address byte prefixes
  localparam logic [3:0] PFX_MAIN = 4'hA;
  localparam logic [3:0] PFX_SPEC = 4'hB;

  // Exact word addresses of the configuration byte and the unlock latch
  localparam logic [13:0] WA_CC = 14'h06CA;
  localparam logic [13:0] WA_UNLOCK = 14'h3F35;

  // Area select field inside the word address
  localparam int WA_SEL_HI = 10;
  localparam int WA_SEL_LO = 9;
  localparam logic [1:0] SEL_ID = 2'h0;
  localparam logic [1:0] SEL_UID = 2'h1;
  localparam logic [1:0] SEL_LOCK = 2'h2;

  // Factory and power-on values
  localparam logic [3:0] CDA_FACTORY = 4'h0;
  localparam logic SWP_FACTORY = 1'b0;
  localparam logic UNLOCK_POWERON = 1'b0;
  localparam logic LOCK_FACTORY = 1'b0;

  // Field positions in the configuration and lock bytes
  localparam int CC_CDA_LSB = 4;
  localparam int CDA_W = 4;
  localparam int CC_SWP_BIT = 1;
  localparam int LOCK_BIT = 1;
  localparam logic [7:0] CC_FILL = 8'hFF;
  localparam logic [7:0] LOCK_FILL = 8'h00;
  localparam logic [7:0] UNLOCK_FILL = 8'h00;
  localparam logic [7:0] NONE_FILL = 8'hFF;

  // Bit slot counts within one byte frame
  localparam logic [3:0] BIT_FIRST = 4'h0;
  localparam logic [3:0] BIT_ONE = 4'h1;
  localparam logic [3:0] BIT_LAST = 4'h7;
  localparam logic [3:0] BIT_ACK = 4'h8;

  // Timing
  localparam int CLK_HZ = 100_000_000;
  localparam int WR_TIME_MS = 5;
  localparam int WR_CYC = WR_TIME_MS * (CLK_HZ / 1000);
  localparam int TMR_W = 20;
  localparam logic [3:0] LOAD_CYC = 4'h8;

  // Link-side sequencer states, Gray along the usual path
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_DEV = 3'b001,
    ST_WA1 = 3'b011,
    ST_WA2 = 3'b010,
    ST_WDATA = 3'b110,
    ST_RDATA = 3'b101
  } ebac_state_t;

  // Memory areas reachable through the word address
  typedef enum logic [2:0] {
    AR_MAIN = 3'b000,
    AR_ID = 3'b001,
    AR_UID = 3'b010,
    AR_LOCK = 3'b011,
    AR_CC = 3'b100,
    AR_UNLOCK = 3'b101,
    AR_NONE = 3'b110
  } ebac_area_t;

endpackage : ebac_pkg

// File: logic/ebac_sync.sv
// Two-flop level synchroniser
`timescale 1ns/1ps
module ebac_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  // First stage, read only by the second
  logic [W-1:0] meta_reg;

  // Both stages clear on reset
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meta_reg <= '0;
      q <= '0;
    end
    else
    begin
      meta_reg <= d;
      q <= meta_reg;
    end
  end

endmodule : ebac_sync

// File: logic/ebac_top.sv
// Two-wire EEPROM slave front end: address decode, special areas and configuration
// What this block does
// RULE1 - Sample on clock rise, drive on fall
// RULE2 - Main array: 13-bit address, 256x32 pages
// RULE3 - Load configuration at power-on before answering
// RULE4 - Respond-all flag or select bits must match
// RULE5 - Bus address setting factory value zero
// RULE6 - Config write only right after unlock command
// RULE7 - Unlock latch cleared after power-on
// RULE8 - Write guard blocks writes except itself
// RULE9 - Write guard cleared when shipped
// RULE10 - Prefix 1010 main, 1011 special areas
// RULE11 - Direction bit: 1 read, 0 write
// RULE12 - Special 00: identification page, 5-bit offset
// RULE13 - Special 01: unique ID, 4-bit offset
// RULE14 - Special 10: page lock bit
// RULE15 - Exact 14-bit pattern selects configuration byte
// RULE16 - Exact 14-bit pattern selects unlock latch
// RULE17 - 32-byte identification page, lockable forever
// RULE18 - 128-bit unique ID, read only
// RULE19 - Self-timed nonvolatile write cycle, 5 ms
// RULE20 - Config byte: select/flag high, guard bit1
// RULE21 - Guard set freezes bus address setting
// RULE22 - Lock read returns lock in bit1
// RULE23 - Locked page: data bytes not acknowledged
// RULE24 - Unmatched device address: no ack, idle
`timescale 1ns/1ps
module ebac_top #(
  parameter int WR_CYCLES = ebac_pkg::WR_CYC,
  parameter logic [127:0] UID_VALUE = 128'h0011_2233_4455_6677_8899_AABB_CCDD_EEFF
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic scl,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n,
  output logic [3:0] bus_address_setting,
  output logic software_write_guard,
  output logic config_write_unlock_latch,
  output logic id_page_locked,
  output logic write_busy,
  output logic config_loaded
);
  // UID_VALUE default is arbitrary

  // System-clock side: synchronised pins and events
  localparam int TMR_W_L = ebac_pkg::TMR_W;
  logic [1:0] pins_s;        // {scl, sda} after two flops
  logic scl_prev_reg;        // Previous synchronised clock level
  logic sda_prev_reg;        // Previous synchronised data level
  logic start_tog_reg;       // Toggles on each start condition
  logic stop_evt;            // Stop condition seen this cycle
  logic wtog_s;              // Write-request toggle, synchronised
  logic wtog_prev_reg;       // Last seen write-request toggle
  logic wpend_reg;           // Nonvolatile write waiting for stop
  logic busy_reg;            // Internal write cycle running
  logic [TMR_W_L-1:0] tmr_reg; // Write cycle countdown
  logic [3:0] load_cnt_reg;  // Power-on load counter
  logic loaded_reg;          // Configuration load finished

  // Link side state
  ebac_pkg::ebac_state_t state_reg;
  ebac_pkg::ebac_area_t area_reg;
  logic [3:0] bit_cnt_reg;   // Bit slot, 8 is the acknowledge slot
  logic [7:0] shift_reg;     // Incoming byte
  logic [7:0] tx_reg;        // Outgoing byte
  logic [7:0] wa_hi_reg;     // First word-address byte
  logic [12:0] ptr_reg;      // Byte pointer inside the area
  logic [12:0] ptr_next;
  logic spec_reg;            // Special-area prefix of this command
  logic ack_ok_reg;          // Acknowledge the byte just received
  logic rd_first_reg;        // Ack slot belongs to the device address
  logic rd_go_reg;           // Load the next read byte
  logic drv_low_reg;         // Pull data low this bit
  logic start_link_reg;      // Start toggle taken on the link clock
  logic start_done_reg;      // Start toggle already consumed
  logic wtog_reg;            // Toggles for each nonvolatile write
  logic [3:0] cda_reg;       // {select bits, respond-all flag}
  logic swp_reg;
  logic lock_reg;
  logic latch_reg;
  logic latch_spent_reg;     // One command has passed since unlock
  logic busy_s;              // Write cycle level on link clock
  logic loaded_s;            // Load level on link clock

  // Decode terms
  logic new_start;
  logic [7:0] byte_in;
  logic byte_done;
  logic ack_slot;
  logic dev_match;
  logic [13:0] wa_full;
  ebac_pkg::ebac_area_t area_dec;
  logic data_ack;
  logic main_we;
  logic id_we;
  logic cc_we;
  logic lock_we;
  logic [7:0] main_rd;
  logic [7:0] id_rd;
  logic [127:0] uid_shift;
  logic [7:0] rd_byte;

  // Pin synchroniser for start and stop detection
  ebac_sync #(.W(2)) u_pin_sync (
    .clk(clk),
    .rst_n(rst_n),
    .d({scl, sda_in}),
    .q(pins_s)
  );

  // Write request and status levels crossing between domains
  ebac_sync #(.W(1)) u_wtog_sync (
    .clk(clk),
    .rst_n(rst_n),
    .d(wtog_reg),
    .q(wtog_s)
  );

  ebac_sync #(.W(2)) u_link_sync (
    .clk(scl),
    .rst_n(rst_n),
    .d({busy_reg, loaded_reg}),
    .q({busy_s, loaded_s})
  );

  // Start and stop seen as data edges while the clock is high
  assign stop_evt = pins_s[1] && scl_prev_reg && pins_s[0] && !sda_prev_reg;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      scl_prev_reg <= 1'b1;
      sda_prev_reg <= 1'b1;
      start_tog_reg <= 1'b0;
    end
    else
    begin
      scl_prev_reg <= pins_s[1];
      sda_prev_reg <= pins_s[0];
      // Start: data falls, clock high
      if (pins_s[1] && scl_prev_reg && !pins_s[0] && sda_prev_reg)
      begin
        start_tog_reg <= ~start_tog_reg;
      end
    end
  end

  // Power-on load of configuration; bus is refused until done
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      load_cnt_reg <= 4'h0;
      loaded_reg <= 1'b0;
    end
    else if (load_cnt_reg != ebac_pkg::LOAD_CYC)
    begin
      load_cnt_reg <= load_cnt_reg + 4'h1;
    end
    else
    begin
      loaded_reg <= 1'b1; // [RULE3]
    end
  end

  // Self-timed write cycle, started by the stop after written data
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wtog_prev_reg <= 1'b0;
      wpend_reg <= 1'b0;
      busy_reg <= 1'b0;
      tmr_reg <= '0;
    end
    else
    begin
      wtog_prev_reg <= wtog_s;
      // Set wins over the stop that would consume it
      if (wtog_s != wtog_prev_reg)
      begin
        wpend_reg <= 1'b1;
      end
      else if (stop_evt)
      begin
        wpend_reg <= 1'b0;
      end
      if (stop_evt && wpend_reg)
      begin
        busy_reg <= 1'b1; // [RULE19]
        tmr_reg <= TMR_W_L'(WR_CYCLES - 1);
      end
      else if (busy_reg)
      begin
        // No bus clocks needed: counts on the system clock
        if (tmr_reg == '0)
        begin
          busy_reg <= 1'b0; // [RULE19]
        end
        else
        begin
          tmr_reg <= tmr_reg - 1'b1;
        end
      end
    end
  end

  // Byte assembly and decode terms on the link side
  assign new_start = start_link_reg != start_done_reg;
  assign byte_in = {shift_reg[6:0], sda_in};
  assign byte_done = !new_start && (state_reg != ebac_pkg::ST_IDLE)
                     && (bit_cnt_reg == ebac_pkg::BIT_LAST);
  assign ack_slot = !new_start && (state_reg != ebac_pkg::ST_IDLE)
                    && (bit_cnt_reg == ebac_pkg::BIT_ACK);
  assign wa_full = {wa_hi_reg[5:0], byte_in};

  // Device address match, refused while loading or writing
  assign dev_match = ((byte_in[7:4] == ebac_pkg::PFX_MAIN)
                      || (byte_in[7:4] == ebac_pkg::PFX_SPEC)) // [RULE10]
                     && (cda_reg[0] || (byte_in[3:1] == cda_reg[3:1])) // [RULE4]
                     && loaded_s && !busy_s; // [RULE3]

  // Area decode at the second word-address byte
  always_comb
  begin
    area_dec = ebac_pkg::AR_NONE;
    if (!spec_reg)
    begin
      area_dec = ebac_pkg::AR_MAIN;
    end
    else if (wa_full == ebac_pkg::WA_CC)
    begin
      area_dec = ebac_pkg::AR_CC; // [RULE15]
    end
    else if (wa_full == ebac_pkg::WA_UNLOCK)
    begin
      area_dec = ebac_pkg::AR_UNLOCK; // [RULE16]
    end
    else if (wa_full[ebac_pkg::WA_SEL_HI:ebac_pkg::WA_SEL_LO] == ebac_pkg::SEL_ID)
    begin
      area_dec = ebac_pkg::AR_ID; // [RULE12]
    end
    else if (wa_full[ebac_pkg::WA_SEL_HI:ebac_pkg::WA_SEL_LO] == ebac_pkg::SEL_UID)
    begin
      area_dec = ebac_pkg::AR_UID; // [RULE13]
    end
    else if (wa_full[ebac_pkg::WA_SEL_HI:ebac_pkg::WA_SEL_LO] == ebac_pkg::SEL_LOCK)
    begin
      area_dec = ebac_pkg::AR_LOCK; // [RULE14]
    end
  end

  // Data byte write permissions; guard blocks all but its own bit
  assign main_we = byte_done && (state_reg == ebac_pkg::ST_WDATA)
                   && (area_reg == ebac_pkg::AR_MAIN) && !swp_reg; // [RULE8]
  assign id_we = byte_done && (state_reg == ebac_pkg::ST_WDATA)
                 && (area_reg == ebac_pkg::AR_ID) && !swp_reg && !lock_reg; // [RULE17]
  assign lock_we = byte_done && (state_reg == ebac_pkg::ST_WDATA)
                   && (area_reg == ebac_pkg::AR_LOCK) && !swp_reg && !lock_reg
                   && byte_in[ebac_pkg::LOCK_BIT];
  assign cc_we = byte_done && (state_reg == ebac_pkg::ST_WDATA)
                 && (area_reg == ebac_pkg::AR_CC) && latch_reg; // [RULE6]

  // Acknowledge for data bytes per area
  always_comb
  begin
    data_ack = 1'b0;
    case (area_reg)
      ebac_pkg::AR_MAIN: data_ack = !swp_reg; // [RULE8]
      ebac_pkg::AR_ID: data_ack = !swp_reg && !lock_reg; // [RULE23]
      ebac_pkg::AR_LOCK: data_ack = !lock_reg;
      ebac_pkg::AR_CC: data_ack = latch_reg; // [RULE6]
      ebac_pkg::AR_UNLOCK: data_ack = 1'b1;
      default: data_ack = 1'b0; // Unique ID never written [RULE18]
    endcase
  end

  // Pointer update: address load, page-wrapped write, read advance
  always_comb
  begin
    ptr_next = ptr_reg;
    if (byte_done && (state_reg == ebac_pkg::ST_WA2))
    begin
      ptr_next = wa_full[12:0]; // [RULE2]
      if (area_dec == ebac_pkg::AR_ID)
      begin
        ptr_next = {8'h00, byte_in[4:0]};
      end
      else if (area_dec == ebac_pkg::AR_UID)
      begin
        ptr_next = {9'h000, byte_in[3:0]};
      end
    end
    else if (main_we || id_we)
    begin
      // Writes stay inside the 32-byte page
      ptr_next = {ptr_reg[12:5], ptr_reg[4:0] + 5'h01}; // [RULE2]
    end
    else if (ack_slot && (state_reg == ebac_pkg::ST_RDATA) && !rd_first_reg)
    begin
      case (area_reg)
        ebac_pkg::AR_MAIN: ptr_next = ptr_reg + 13'h0001;
        ebac_pkg::AR_ID: ptr_next = {8'h00, ptr_reg[4:0] + 5'h01};
        ebac_pkg::AR_UID: ptr_next = {9'h000, ptr_reg[3:0] + 4'h1};
        default: ptr_next = ptr_reg; // Fixed bytes repeat
      endcase
    end
  end

  // Main array and identification page
  ebac_mem #(.AW(ebac_pkg::MAIN_AW), .DW(ebac_pkg::BYTE_W)) u_main_mem (
    .clk(scl),
    .rst_n(rst_n),
    .we(main_we),
    .waddr(ptr_reg),
    .wdata(byte_in),
    .raddr(ptr_next),
    .rdata(main_rd)
  );

  ebac_mem #(.AW(ebac_pkg::ID_AW), .DW(ebac_pkg::BYTE_W)) u_id_mem (
    .clk(scl),
    .rst_n(rst_n),
    .we(id_we),
    .waddr(ptr_reg[4:0]),
    .wdata(byte_in),
    .raddr(ptr_next[4:0]),
    .rdata(id_rd)
  );

  // Outgoing byte per area; unique ID byte 0 is the top byte
  assign uid_shift = UID_VALUE << {ptr_reg[3:0], 3'b000}; // [RULE18]

  always_comb
  begin
    rd_byte = ebac_pkg::NONE_FILL;
    case (area_reg)
      ebac_pkg::AR_MAIN: rd_byte = main_rd;
      ebac_pkg::AR_ID: rd_byte = id_rd;
      ebac_pkg::AR_UID: rd_byte = uid_shift[127:120];
      ebac_pkg::AR_LOCK:
      begin
        rd_byte = ebac_pkg::LOCK_FILL;
        rd_byte[ebac_pkg::LOCK_BIT] = lock_reg; // [RULE22]
      end
      ebac_pkg::AR_CC:
      begin
        rd_byte = ebac_pkg::CC_FILL; // [RULE20]
        rd_byte[ebac_pkg::CC_CDA_LSB +: ebac_pkg::CDA_W] = cda_reg;
        rd_byte[ebac_pkg::CC_SWP_BIT] = swp_reg;
      end
      ebac_pkg::AR_UNLOCK: rd_byte = {ebac_pkg::UNLOCK_FILL[7:1], latch_reg};
      default: rd_byte = ebac_pkg::NONE_FILL;
    endcase
  end

  // Sequencer: bits sampled on the rising link clock
  always_ff @(posedge scl or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_reg <= ebac_pkg::ST_IDLE;
      bit_cnt_reg <= ebac_pkg::BIT_FIRST;
      shift_reg <= 8'h00;
      start_done_reg <= 1'b0;
      ack_ok_reg <= 1'b0;
      rd_first_reg <= 1'b0;
      rd_go_reg <= 1'b0;
      spec_reg <= 1'b0;
      wa_hi_reg <= 8'h00;
      area_reg <= ebac_pkg::AR_MAIN;
    end
    else if (new_start)
    begin
      // First rising edge after a start is device-address bit 7
      start_done_reg <= start_link_reg;
      state_reg <= ebac_pkg::ST_DEV;
      bit_cnt_reg <= ebac_pkg::BIT_ONE;
      shift_reg <= {7'h00, sda_in}; // [RULE1]
      ack_ok_reg <= 1'b0;
      rd_go_reg <= 1'b0;
    end
    else if (state_reg != ebac_pkg::ST_IDLE)
    begin
      if (byte_done)
      begin
        bit_cnt_reg <= ebac_pkg::BIT_ACK;
        case (state_reg)
          ebac_pkg::ST_DEV:
          begin
            ack_ok_reg <= dev_match;
            spec_reg <= byte_in[7:4] == ebac_pkg::PFX_SPEC; // [RULE10]
            rd_first_reg <= 1'b1;
            if (!dev_match)
            begin
              state_reg <= ebac_pkg::ST_IDLE; // [RULE24]
            end
            else if (byte_in[0])
            begin
              state_reg <= ebac_pkg::ST_RDATA; // [RULE11]
            end
            else
            begin
              state_reg <= ebac_pkg::ST_WA1; // [RULE11]
            end
          end
          ebac_pkg::ST_WA1:
          begin
            ack_ok_reg <= 1'b1;
            wa_hi_reg <= byte_in;
            state_reg <= ebac_pkg::ST_WA2;
          end
          ebac_pkg::ST_WA2:
          begin
            ack_ok_reg <= 1'b1;
            area_reg <= area_dec;
            state_reg <= ebac_pkg::ST_WDATA;
          end
          ebac_pkg::ST_WDATA: ack_ok_reg <= data_ack;
          default: ack_ok_reg <= 1'b0;
        endcase
      end
      else if (ack_slot)
      begin
        bit_cnt_reg <= ebac_pkg::BIT_FIRST;
        ack_ok_reg <= 1'b0;
        rd_first_reg <= 1'b0;
        // Master ack (low) keeps a read going; nack ends it
        if (state_reg == ebac_pkg::ST_RDATA)
        begin
          rd_go_reg <= rd_first_reg || !sda_in;
          if (!rd_first_reg && sda_in)
          begin
            state_reg <= ebac_pkg::ST_IDLE;
          end
        end
      end
      else
      begin
        bit_cnt_reg <= bit_cnt_reg + 4'h1;
        shift_reg <= byte_in; // [RULE1]
      end
    end
  end

  // Pointer register
  always_ff @(posedge scl or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ptr_reg <= 13'h0000;
    end
    else
    begin
      ptr_reg <= ptr_next;
    end
  end

  // Configuration, guard, lock and unlock latch; reset gives factory values
  always_ff @(posedge scl or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cda_reg <= ebac_pkg::CDA_FACTORY; // [RULE5]
      swp_reg <= ebac_pkg::SWP_FACTORY; // [RULE9]
      lock_reg <= ebac_pkg::LOCK_FACTORY;
      latch_reg <= ebac_pkg::UNLOCK_POWERON; // [RULE7]
      latch_spent_reg <= 1'b0;
      wtog_reg <= 1'b0;
    end
    else
    begin
      if (byte_done && (state_reg == ebac_pkg::ST_DEV) && dev_match)
      begin
        // The command after the unlock may use it; the next clears it
        if (latch_reg && !latch_spent_reg)
        begin
          latch_spent_reg <= 1'b1;
        end
        else
        begin
          latch_reg <= 1'b0; // [RULE6]
          latch_spent_reg <= 1'b0;
        end
      end
      else if (byte_done && (state_reg == ebac_pkg::ST_WA2)
               && (area_dec == ebac_pkg::AR_UNLOCK))
      begin
        latch_reg <= 1'b1; // [RULE16]
        latch_spent_reg <= 1'b0;
      end
      else if (cc_we)
      begin
        latch_reg <= 1'b0; // [RULE6]
        swp_reg <= byte_in[ebac_pkg::CC_SWP_BIT]; // [RULE8]
        // Guard set: address values in the byte are ignored
        if (!swp_reg)
        begin
          cda_reg <= byte_in[ebac_pkg::CC_CDA_LSB +: ebac_pkg::CDA_W]; // [RULE21]
        end
      end
      if (lock_we)
      begin
        lock_reg <= 1'b1; // [RULE17]
      end
      // Each nonvolatile change requests a timed write cycle
      if (main_we || id_we || lock_we || cc_we)
      begin
        wtog_reg <= ~wtog_reg; // [RULE19]
      end
    end
  end

  // Start toggle is stable long before the first falling edge after a start
  always_ff @(negedge scl or negedge rst_n)
  begin
    if (!rst_n)
    begin
      start_link_reg <= 1'b0;
    end
    else
    begin
      start_link_reg <= start_tog_reg;
    end
  end

  // Output bits change only on the falling link clock
  always_ff @(negedge scl or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tx_reg <= 8'h00;
      drv_low_reg <= 1'b0;
    end
    else if (start_tog_reg != start_done_reg)
    begin
      drv_low_reg <= 1'b0;
    end
    else if ((state_reg == ebac_pkg::ST_RDATA) && (bit_cnt_reg == ebac_pkg::BIT_FIRST))
    begin
      tx_reg <= rd_byte;
      drv_low_reg <= rd_go_reg && !rd_byte[7]; // [RULE1]
    end
    else if ((state_reg == ebac_pkg::ST_RDATA) && (bit_cnt_reg < ebac_pkg::BIT_ACK))
    begin
      tx_reg <= {tx_reg[6:0], 1'b1};
      drv_low_reg <= rd_go_reg && !tx_reg[6]; // [RULE1]
    end
    else
    begin
      // Ack slot: pull low only for accepted bytes
      drv_low_reg <= (bit_cnt_reg == ebac_pkg::BIT_ACK) && ack_ok_reg;
    end
  end

  // Open-drain pin and status outputs
  assign sda_out = 1'b0;
  assign sda_oe_n = !drv_low_reg;
  assign bus_address_setting = cda_reg;
  assign software_write_guard = swp_reg;
  assign config_write_unlock_latch = latch_reg;
  assign id_page_locked = lock_reg;
  assign write_busy = busy_reg;
  assign config_loaded = loaded_reg;

endmodule : ebac_top
